// ---- rtl/dtsw_top.sv ----
/*
 * drive telegram status word block: decodes the controller's second
 * control word and two encoder control words, assembles the second
 * status word, two encoder status words and the first safety status
 * word, and runs the sign-of-life counters.
 * assumes a classic wishbone master, inputs synchronous to clk_i and a
 * one-cycle telegram_tick_i per telegram cycle.
 */
// Added by the designer: the Wishbone slave port and the address map.
// Operation
// - control word two steers drive, status reports
// - bit 6 disables integrator, group 102/105
// - status bit 6 integrator or alarm bit 1
// - control bit 8 requests fixed-stop travel
// - status bit 8 shows fixed-stop active
// - device sign-of-life in status bits 12-15
// - status bit 5 brake open or alarm 0
// - status bit 10 pulses enabled, group 3/5
// - encoder requests 0-3 confirmed in status
// - probe bits 8-9, values in 4-7
// - fault bit 15, acknowledge shown bit 11
// - absolute value and parking request/confirm
// - second encoder identical to the first
// - safety status word bit layout
module dtsw_top (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // interrupt
    output logic                        irq_o,
    // drive side
    input  wire logic                   telegram_tick_i,
    input  wire dtsw_pkg::dtsw_drv_in_t drv_i,
    input  wire dtsw_pkg::dtsw_safe_in_t safe_i,
    output dtsw_pkg::dtsw_drv_out_t     drv_o,
    output logic      [3:0]             dev_sol_o,
    // encoders
    input  wire dtsw_pkg::dtsw_enc_in_t enc_i [dtsw_pkg::NUM_ENC],
    output dtsw_pkg::dtsw_enc_out_t     enc_o [dtsw_pkg::NUM_ENC]
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]             cw2_r;
    logic [15:0]             enc_cw_r [dtsw_pkg::NUM_ENC];
    logic                    grp_hi_r;
    logic [dtsw_pkg::IRQ_W-1:0] irq_sts_r;
    logic [dtsw_pkg::IRQ_W-1:0] irq_en_r;
    logic [dtsw_pkg::IRQ_W-1:0] irq_sts_nxt;
    logic [3:0]              dev_sol_r;
    logic [3:0]              last_sol_r;
    logic                    sol_seen_r;
    logic [dtsw_pkg::NUM_ENC-1:0] flt_d_r;
    logic                    msg_d_r;
    logic [31:0]             dat_r;
    logic                    ack_r;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        req      = wb_cyc_i & wb_stb_i;
    wire        wr_take  = req & wb_we_i & ack_r;
    wire [7:0]  adr      = {wb_adr_i[7:2], 2'b00};
    wire        hit_cw2  = adr == dtsw_pkg::OFS_CW2;
    wire        hit_e1   = adr == dtsw_pkg::OFS_ENC1_CW;
    wire        hit_e2   = adr == dtsw_pkg::OFS_ENC2_CW;
    wire        hit_cfg  = adr == dtsw_pkg::OFS_CFG;
    wire        hit_clr  = adr == dtsw_pkg::OFS_IRQ_CLR;
    wire        hit_en   = adr == dtsw_pkg::OFS_IRQ_EN;
    wire [15:0] bmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [15:0] msk);
        merge = (old & ~msk) | (dat & msk);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // status word assembly
    wire [15:0] sw2;
    wire [15:0] safe_sw;
    wire [15:0] enc_sw [dtsw_pkg::NUM_ENC];

    // group 102/105 reports brake and integrator, group 3/5 alarm class
    assign sw2 = {dev_sol_r,
                  1'b0,
                  ~grp_hi_r & drv_i.pulses_en,
                  1'b0,
                  drv_i.fixed_stop_act,
                  1'b0,
                  grp_hi_r ? drv_o.integ_dis : drv_i.alarm_cls[1],
                  grp_hi_r ? drv_i.brake_open : drv_i.alarm_cls[0],
                  5'h00};

    assign safe_sw = {safe_i.msg_act,
                      1'b0,
                      safe_i.safe_direction_guard_neg,
                      safe_i.safe_direction_guard_pos,
                      1'b0,
                      safe_i.speed_limit_pick,
                      safe_i.safe_accel_limit_sel,
                      safe_i.int_event,
                      safe_i.safe_speed_limit_sel,
                      safe_i.safe_standstill_hold_sel,
                      safe_i.safe_speed_limit_act,
                      safe_i.safe_standstill_hold_sel,
                      safe_i.safe_stop_two,
                      safe_i.safe_stop_one,
                      safe_i.safe_torque_off};

    ////////////////////////////////////////////////////////////////////////////
    // per-encoder control decode and status, same layout for both
    genvar g;
    generate
        for (g = 0; g < dtsw_pkg::NUM_ENC; g++)
        begin : g_enc
            wire hit = (g == 0) ? hit_e1 : hit_e2;
            // reserved control bits 8-12 are never decoded
            assign enc_sw[g] = {enc_i[g].fault,
                                enc_o[g].park_req & enc_i[g].park_ok,
                                enc_o[g].abs_req & enc_i[g].abs_ok,
                                1'b0,
                                enc_o[g].fault_ack,
                                1'b0,
                                enc_i[g].probe,
                                enc_i[g].value,
                                enc_o[g].fn_req & enc_i[g].fn_ok};
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    enc_cw_r[g] <= dtsw_pkg::RST_WORD;
                else if (wr_take & hit)
                    enc_cw_r[g] <= merge(enc_cw_r[g], wb_dat_i[15:0], bmask);
            end
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    enc_o[g] <= '0;
                else
                begin
                    enc_o[g].fn_req    <= enc_cw_r[g][3:0];
                    enc_o[g].cmd       <= enc_cw_r[g][dtsw_pkg::ENC_CMD_LSB +: 3];
                    enc_o[g].mode      <= enc_cw_r[g][dtsw_pkg::ENC_MODE];
                    enc_o[g].abs_req   <= enc_cw_r[g][dtsw_pkg::ENC_ABS];
                    enc_o[g].park_req  <= enc_cw_r[g][dtsw_pkg::ENC_PARK];
                    enc_o[g].fault_ack <= enc_cw_r[g][dtsw_pkg::ENC_FLT_ACK];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read mux; write-only words read back as zero
    wire [15:0] rd_word =
        (adr == dtsw_pkg::OFS_SW2)     ? sw2 :
        (adr == dtsw_pkg::OFS_ENC1_SW) ? enc_sw[0] :
        (adr == dtsw_pkg::OFS_ENC2_SW) ? enc_sw[1] :
        (adr == dtsw_pkg::OFS_SAFE_SW) ? safe_sw :
        hit_cfg                        ? {15'h0000, grp_hi_r} :
        (adr == dtsw_pkg::OFS_IRQ_STS) ? {12'h000, irq_sts_r} :
        hit_en                         ? {12'h000, irq_en_r} : 16'h0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            dat_r <= {16'h0000, rd_word};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control word two and configuration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cw2_r <= dtsw_pkg::RST_WORD;
        else if (wr_take & hit_cw2)
            cw2_r <= merge(cw2_r, wb_dat_i[15:0], bmask);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            grp_hi_r <= 1'b0;
        else if (wr_take & hit_cfg & wb_sel_i[0])
            grp_hi_r <= wb_dat_i[dtsw_pkg::CFG_GRP_HI];
    end

    // group 3/5 treats bit 6 as reserved, so it never reaches the drive
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            drv_o <= '0;
        else
        begin
            drv_o.integ_dis      <= grp_hi_r & cw2_r[dtsw_pkg::CW2_INTEG_DIS];
            drv_o.fixed_stop_req <= cw2_r[dtsw_pkg::CW2_FIX_STOP];
            drv_o.ctrl_sol       <= cw2_r[dtsw_pkg::SOL_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sign-of-life: own counter advances, partner counter is checked
    wire [3:0] sol_exp   = last_sol_r + dtsw_pkg::SOL_STEP;
    wire       sol_stall = telegram_tick_i & sol_seen_r &
                           (cw2_r[dtsw_pkg::SOL_LSB +: 4] != sol_exp);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dev_sol_r  <= dtsw_pkg::RST_SOL;
            last_sol_r <= dtsw_pkg::RST_SOL;
            sol_seen_r <= 1'b0;
        end
        else if (telegram_tick_i)
        begin
            dev_sol_r  <= dev_sol_r + dtsw_pkg::SOL_STEP;
            last_sol_r <= cw2_r[dtsw_pkg::SOL_LSB +: 4];
            sol_seen_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: rising fault and message edges, partner stall
    wire [dtsw_pkg::IRQ_W-1:0] irq_evt;
    wire [dtsw_pkg::IRQ_W-1:0] irq_clr;

    assign irq_evt[dtsw_pkg::IRQ_ENC1_FLT]  = enc_i[0].fault & ~flt_d_r[0];
    assign irq_evt[dtsw_pkg::IRQ_ENC2_FLT]  = enc_i[1].fault & ~flt_d_r[1];
    assign irq_evt[dtsw_pkg::IRQ_SAFE_MSG]  = safe_i.msg_act & ~msg_d_r;
    assign irq_evt[dtsw_pkg::IRQ_SOL_STALL] = sol_stall;
    assign irq_clr = (wr_take & hit_clr & wb_sel_i[0]) ?
                     wb_dat_i[dtsw_pkg::IRQ_W-1:0] : '0;
    // an event in the clearing cycle survives the clear
    assign irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_evt;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_sts_r <= '0;
            irq_en_r  <= '0;
            flt_d_r   <= '0;
            msg_d_r   <= 1'b0;
            irq_o     <= 1'b0;
        end
        else
        begin
            irq_sts_r <= irq_sts_nxt;
            if (wr_take & hit_en & wb_sel_i[0])
                irq_en_r <= wb_dat_i[dtsw_pkg::IRQ_W-1:0];
            flt_d_r   <= {enc_i[1].fault, enc_i[0].fault};
            msg_d_r   <= safe_i.msg_act;
            irq_o     <= |(irq_sts_nxt & irq_en_r);
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;
    assign dev_sol_o = dev_sol_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd_sw2;
        req & ~wb_we_i & (adr == dtsw_pkg::OFS_SW2) & ~ack_r ##1 ack_r;
    endsequence

    sequence s_wr_e1_ack;
        wr_take & hit_e1 & wb_sel_i[1] & wb_dat_i[15];
    endsequence

    a_integ_dis_grp: assert property (
        !grp_hi_r |=> !drv_o.integ_dis)
        else $error("integrator disable leaked in group 3/5");

    a_fix_stop_req: assert property (
        wr_take & hit_cw2 & wb_sel_i[1] ##1 1'b1
        |=> drv_o.fixed_stop_req == $past(wb_dat_i[8], 2))
        else $error("fixed stop request not forwarded");

    a_sw2_fixed_stop: assert property (
        s_rd_sw2 |-> wb_dat_o[8] == $past(drv_i.fixed_stop_act))
        else $error("status bit 8 wrong");

    a_sw2_sol_rd: assert property (
        s_rd_sw2 |-> wb_dat_o[15:12] == $past(dev_sol_r))
        else $error("device sign-of-life misplaced");

    a_sw2_reserved: assert property (
        s_rd_sw2 |-> wb_dat_o[4:0] == 5'h00 && !wb_dat_o[7] && !wb_dat_o[9]
                     && !wb_dat_o[11] && wb_dat_o[31:16] == 16'h0000)
        else $error("reserved status bit set");

    a_sw2_pulses_grp: assert property (
        s_rd_sw2 |-> wb_dat_o[10] == ($past(!grp_hi_r) && $past(drv_i.pulses_en)))
        else $error("pulse enable bit wrong");

    a_sol_advance: assert property (
        telegram_tick_i |=> dev_sol_r == $past(dev_sol_r) + 4'h1)
        else $error("sign-of-life did not advance");

    a_sol_hold: assert property (
        !telegram_tick_i |=> $stable(dev_sol_r))
        else $error("sign-of-life moved without tick");

    a_enc_flt_ack: assert property (
        s_wr_e1_ack |=> ##1 enc_o[0].fault_ack && enc_sw[0][11])
        else $error("fault acknowledge not shown");

    a_irq_set_wins: assert property (
        irq_evt[0] & irq_clr[0] |=> irq_sts_r[0])
        else $error("event lost under clear");

    a_enc_confirm: assert property (
        enc_sw[1][3:0] == (enc_o[1].fn_req & enc_i[1].fn_ok))
        else $error("encoder two confirm wrong");

    sequence s_rd_enc1;
        req & ~wb_we_i & (adr == dtsw_pkg::OFS_ENC1_SW) & ~ack_r ##1 ack_r;
    endsequence

    sequence s_rd_safe;
        req & ~wb_we_i & (adr == dtsw_pkg::OFS_SAFE_SW) & ~ack_r ##1 ack_r;
    endsequence

    a_ack_pulse: assert property (
        ack_r |=> !ack_r)
        else $error("acknowledge held too long");

    a_sw2_integ_grp: assert property (
        s_rd_sw2 |-> wb_dat_o[6] == ($past(grp_hi_r) ? $past(drv_o.integ_dis)
                                                     : $past(drv_i.alarm_cls[1])))
        else $error("status bit 6 wrong for group");

    a_sw2_brake_grp: assert property (
        s_rd_sw2 |-> wb_dat_o[5] == ($past(grp_hi_r) ? $past(drv_i.brake_open)
                                                     : $past(drv_i.alarm_cls[0])))
        else $error("status bit 5 wrong for group");

    a_ctrl_sol_fwd: assert property (
        wr_take & hit_cw2 & wb_sel_i[1] |=> ##1
        drv_o.ctrl_sol == $past(wb_dat_i[15:12], 2))
        else $error("controller sign-of-life not forwarded");

    a_enc_probe_rd: assert property (
        s_rd_enc1 |-> wb_dat_o[9:4] == {$past(enc_i[0].probe), $past(enc_i[0].value)})
        else $error("probe or value bits wrong");

    a_enc_fault_rd: assert property (
        s_rd_enc1 |-> wb_dat_o[15] == $past(enc_i[0].fault) && !wb_dat_o[12] && !wb_dat_o[10])
        else $error("encoder fault bit wrong");

    a_enc2_park_req: assert property (
        wr_take & hit_e2 & wb_sel_i[1] |=> ##1
        enc_o[1].park_req == $past(wb_dat_i[14], 2))
        else $error("encoder two parking request lost");

    a_safe_rd: assert property (
        s_rd_safe |-> wb_dat_o[0] == $past(safe_i.safe_torque_off)
                      && wb_dat_o[7] == $past(safe_i.int_event)
                      && wb_dat_o[15] == $past(safe_i.msg_act) && !wb_dat_o[14])
        else $error("safety status bits wrong");

    // a stalled partner must be flagged one cycle after the tick that shows it
    a_stall_flag: assert property (
        sol_stall |=> irq_sts_r[dtsw_pkg::IRQ_SOL_STALL])
        else $error("partner stall not flagged");

endmodule : dtsw_top

// ---- rtl/dtsw_pkg.sv ----
/*
 * constants, field layouts and carrier structs for the drive telegram
 * status word block. assumes one 200 MHz clock and a 32-bit wishbone bus.
 */
package dtsw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CW2     = 8'h00;
    localparam logic [7:0] OFS_SW2     = 8'h04;
    localparam logic [7:0] OFS_ENC1_CW = 8'h08;
    localparam logic [7:0] OFS_ENC1_SW = 8'h0C;
    localparam logic [7:0] OFS_ENC2_CW = 8'h10;
    localparam logic [7:0] OFS_ENC2_SW = 8'h14;
    localparam logic [7:0] OFS_SAFE_SW = 8'h18;
    localparam logic [7:0] OFS_CFG     = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STS = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h28;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CW2_INTEG_DIS = 6;
    localparam int CW2_FIX_STOP  = 8;
    localparam int SOL_LSB       = 12;
    localparam int ENC_CMD_LSB   = 4;
    localparam int ENC_MODE      = 7;
    localparam int ENC_ABS       = 13;
    localparam int ENC_PARK      = 14;
    localparam int ENC_FLT_ACK   = 15;
    localparam int CFG_GRP_HI    = 0;
    localparam int IRQ_W         = 4;
    localparam int IRQ_ENC1_FLT  = 0;
    localparam int IRQ_ENC2_FLT  = 1;
    localparam int IRQ_SAFE_MSG  = 2;
    localparam int IRQ_SOL_STALL = 3;
    localparam int NUM_ENC       = 2;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0]  RST_SOL  = 4'h0;
    localparam logic [3:0]  SOL_STEP = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic       brake_open;
        logic [1:0] alarm_cls;
        logic       fixed_stop_act;
        logic       pulses_en;
    } dtsw_drv_in_t;

    typedef struct packed {
        logic       integ_dis;
        logic       fixed_stop_req;
        logic [3:0] ctrl_sol;
    } dtsw_drv_out_t;

    typedef struct packed {
        logic [3:0] fn_ok;
        logic [3:0] value;
        logic [1:0] probe;
        logic       fault;
        logic       abs_ok;
        logic       park_ok;
    } dtsw_enc_in_t;

    typedef struct packed {
        logic [3:0] fn_req;
        logic [2:0] cmd;
        logic       mode;
        logic       abs_req;
        logic       park_req;
        logic       fault_ack;
    } dtsw_enc_out_t;

    typedef struct packed {
        logic       safe_torque_off;
        logic       safe_stop_one;
        logic       safe_stop_two;
        logic       safe_standstill_hold_sel;
        logic       safe_speed_limit_act;
        logic       safe_speed_limit_sel;
        logic       int_event;
        logic       safe_accel_limit_sel;
        logic [1:0] speed_limit_pick;
        logic       safe_direction_guard_pos;
        logic       safe_direction_guard_neg;
        logic       msg_act;
    } dtsw_safe_in_t;

endpackage : dtsw_pkg

// ---- sim/dtsw_enc_model.sv ----
/*
 * far-side encoder model: answers the block's encoder requests.
 * assumes one clock, synchronous reset and the telegram tick.
 */
module dtsw_enc_model (
    // clock, reset, tick
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    tick_i,
    // bench controls
    input  wire logic                    slow_i,
    input  wire logic                    fault_i,
    input  wire logic [1:0]              probe_i,
    input  wire logic [3:0]              value_i,
    // block side
    input  wire dtsw_pkg::dtsw_enc_out_t enc_req_i,
    output dtsw_pkg::dtsw_enc_in_t       enc_rsp_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [5:0] held_r;

    ////////////////////////////////////////
    // slow mode confirms only what stood at the last tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            held_r <= 6'h00;
        else if (tick_i)
            held_r <= {enc_req_i.fn_req, enc_req_i.abs_req, enc_req_i.park_req};
    end

    assign enc_rsp_o = '{fn_ok: slow_i ? held_r[5:2] : 4'hF,
                         abs_ok: slow_i ? held_r[1] : 1'b1,
                         park_ok: slow_i ? held_r[0] : 1'b1,
                         value: value_i,
                         probe: probe_i,
                         fault: fault_i};
endmodule : dtsw_enc_model

// ---- sim/test_drive_telegram_status_words.sv ----
/*
 * bench for the drive telegram status word block: wishbone tasks,
 * encoder models on both encoder ports, drive and safety levels.
 * assumes the design package and top module are compiled first.
 */
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_drive_telegram_status_words;
    timeunit 1ns;
    timeprecision 100ps;

    logic                    clk, rst, cyc, stb, we, ack, irq, tick;
    logic [7:0]              adr;
    logic [3:0]              sel, dev_sol;
    logic [31:0]             dat_w, dat_r;
    dtsw_pkg::dtsw_drv_in_t  drv_in;
    dtsw_pkg::dtsw_drv_out_t drv_out;
    dtsw_pkg::dtsw_safe_in_t safe_in;
    dtsw_pkg::dtsw_enc_in_t  enc_in [2];
    dtsw_pkg::dtsw_enc_out_t enc_out [2];
    logic [1:0]              slow, fault;
    logic [1:0]              probe [2];
    logic [3:0]              value [2];
    logic [15:0]             d;
    int                      errors, cmp_count;
    logic [15:0] safe_exp [13] = '{16'h0001, 16'h0002, 16'h0004, 16'h0028, 16'h0010,
        16'h0040, 16'h0080, 16'h0100, 16'h0400, 16'h0200, 16'h1000, 16'h2000, 16'h8000};

    dtsw_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .irq_o(irq), .telegram_tick_i(tick), .drv_i(drv_in), .safe_i(safe_in),
        .drv_o(drv_out), .dev_sol_o(dev_sol), .enc_i(enc_in), .enc_o(enc_out));

    for (genvar g = 0; g < 2; g++)
    begin : g_enc
        dtsw_enc_model u_enc (.clk_i(clk), .rst_i(rst), .tick_i(tick), .slow_i(slow[g]),
            .fault_i(fault[g]), .probe_i(probe[g]), .value_i(value[g]),
            .enc_req_i(enc_out[g]), .enc_rsp_o(enc_in[g]));
    end

    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
                        output logic [15:0] rdat);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {16'h0000, wd};
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_r[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50)
        begin
            errors++;
            finish_test();
        end
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] wd);
        logic [15:0] x;
        xfer(1'b1, a, wd, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] rdat);
        xfer(1'b0, a, 16'h0000, rdat);
    endtask : rd

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc_wait

    task automatic pulse_tick();
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(posedge clk);
    endtask : pulse_tick

    ////////////////////////////////////////
    initial
    begin
        errors = 0;
        cmp_count = 0;
        rst <= 1'b1;
        {cyc, stb, we, tick} <= 4'h0;
        adr <= 8'h00;
        sel <= 4'h3;
        dat_w <= 32'h00000000;
        drv_in <= '0;
        safe_in <= '0;
        {slow, fault} <= 4'h0;
        probe <= '{2'h0, 2'h0};
        value <= '{4'h0, 4'h0};
        cyc_wait(20);
        rst <= 1'b0;
        // everything reads zero, unmapped 2C too
        for (int i = 0; i < 12; i++)
        begin
            rd(8'(i * 4), d);
            `CHK(d, 16'h0000)
        end
        // group 3/5: integrator bit ignored, reserved bits dropped
        drv_in <= '{brake_open: 1'b1, alarm_cls: 2'b10, fixed_stop_act: 1'b1, pulses_en: 1'b1};
        wr(dtsw_pkg::OFS_CW2, 16'h0FFF);
        cyc_wait(3);
        `CHK(drv_out, 6'b01_0000)
        rd(dtsw_pkg::OFS_SW2, d);
        `CHK(d, 16'h0540)
        // group 102/105
        wr(dtsw_pkg::OFS_CFG, 16'h0001);
        cyc_wait(3);
        `CHK(drv_out, 6'b11_0000)
        rd(dtsw_pkg::OFS_SW2, d);
        `CHK(d, 16'h0160)
        // sign of life through a wrap, controller advancing
        for (int i = 0; i < 17; i++)
        begin
            wr(dtsw_pkg::OFS_CW2, {4'(i), 12'h000});
            pulse_tick();
            `CHK(dev_sol, 4'(i + 1))
        end
        `CHK(drv_out.ctrl_sol, 4'h0)
        rd(dtsw_pkg::OFS_SW2, d);
        `CHK(d[15:12], 4'h1)
        rd(dtsw_pkg::OFS_IRQ_STS, d);
        `CHK(d, 16'h0000)
        // controller counter stalls
        pulse_tick();
        rd(dtsw_pkg::OFS_IRQ_STS, d);
        `CHK(d, 16'h0008)
        // both encoders, second model answers only at tick
        for (int e = 0; e < 2; e++)
        begin
            slow[e] <= 1'(e);
            fault[e] <= 1'b1;
            probe[e] <= 2'b10;
            value[e] <= 4'h9;
            wr(e ? dtsw_pkg::OFS_ENC2_CW : dtsw_pkg::OFS_ENC1_CW, 16'hE0AF);
            cyc_wait(3);
            `CHK(enc_out[e], 11'b1111_010_1111)
            rd(e ? dtsw_pkg::OFS_ENC2_SW : dtsw_pkg::OFS_ENC1_SW, d);
            `CHK(d, e ? 16'h8A90 : 16'hEA9F)
        end
        pulse_tick();
        rd(dtsw_pkg::OFS_ENC2_SW, d);
        `CHK(d, 16'hEA9F)
        // interrupt: masked, enabled, cleared
        rd(dtsw_pkg::OFS_IRQ_STS, d);
        `CHK(d, 16'h000B)
        `CHK(irq, 1'b0)
        wr(dtsw_pkg::OFS_IRQ_EN, 16'h0002);
        cyc_wait(2);
        `CHK(irq, 1'b1)
        wr(dtsw_pkg::OFS_IRQ_CLR, 16'h0002);
        cyc_wait(2);
        `CHK(irq, 1'b0)
        // safety word, one field at a time
        for (int k = 0; k < 13; k++)
        begin
            safe_in <= 13'h1000 >> k;
            rd(dtsw_pkg::OFS_SAFE_SW, d);
            `CHK(d, safe_exp[k])
        end
        rd(dtsw_pkg::OFS_IRQ_STS, d);
        `CHK(d, 16'h000D)
        wr(dtsw_pkg::OFS_IRQ_CLR, 16'h000F);
        rd(dtsw_pkg::OFS_IRQ_STS, d);
        `CHK(d, 16'h0000)
        // fault rises in the very cycle the clear lands: set wins
        fault[0] <= 1'b0;
        cyc_wait(2);
        fork
            wr(dtsw_pkg::OFS_IRQ_CLR, 16'h0001);
            begin
                @(posedge clk);
                fault[0] <= 1'b1;
            end
        join
        rd(dtsw_pkg::OFS_IRQ_STS, d);
        `CHK(d, 16'h0001)
        finish_test();
    end
endmodule : test_drive_telegram_status_words
